//--- inc/serial_flags_pkg.sv
package serial_flags_pkg;

  // ****************************************
  // register map (word byte addresses)
  // ****************************************
  localparam logic [3:0] STATUS_OFS = 4'h0;
  localparam logic [3:0] DATA_OFS   = 4'h4;
  localparam logic [3:0] CTRL_OFS   = 4'h8;

  // ****************************************
  // status bit positions
  // ****************************************
  localparam int TXE_BIT  = 7;
  localparam int TXD_BIT  = 6;
  localparam int RXR_BIT  = 5;
  localparam int IDL_BIT  = 4;
  localparam int OVR_BIT  = 3;
  localparam int NSE_BIT  = 2;
  localparam int FRM_BIT  = 1;
  localparam int PAR_BIT  = 0;

  // ****************************************
  // control bit positions
  // ****************************************
  localparam int CTL_TX_EMPTY_IE = 7;
  localparam int CTL_TX_DONE_IE  = 6;
  localparam int CTL_RX_IE       = 5;
  localparam int CTL_QUIET_IE    = 4;
  localparam int CTL_PAR_EN      = 2;
  localparam int CTL_PAR_SEL     = 1;
  localparam int CTL_PAR_IE      = 0;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] STATUS_RST = 8'hc0;
  localparam logic [7:0] CTRL_RST   = 8'h00;

  // ****************************************
  // engine side carriers
  // ****************************************
  typedef struct packed {
    logic       load_ready;
    logic       frame_done;
    logic       frame_was_data;
  } tx_evt_t;

  typedef struct packed {
    logic       word_done;
    logic [7:0] word;
    logic       parity_bit;
    logic       noise;
    logic       framing;
    logic       idle_line;
  } rx_evt_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_ARMED = 2'b01
  } clr_seq_t;

endpackage

//--- rtl/async_serial_status_flags.sv
`timescale 1ns/1ps
`default_nettype none
module async_serial_status_flags
  import serial_flags_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       srst_in,
  input  wire logic [3:0] avs_address_in,
  input  wire logic       avs_read_in,
  input  wire logic       avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic [31:0]     avs_readdata_out,
  output logic            avs_waitrequest_out,
  input  wire tx_evt_t    tx_evt_in,
  input  wire rx_evt_t    rx_evt_in,
  output logic            tx_load_out,
  output logic [7:0]      tx_word_out,
  output logic            irq_out
);

  default clocking chk_clk @(posedge ref_clk_in);
  endclocking
  default disable iff (srst_in);

  // ****************************************
  // state
  // ****************************************
  logic [7:0]  status;
  logic [7:0]  ctrl;
  logic [7:0]  tx_holding_reg;
  logic [7:0]  rx_holding_reg;
  logic [7:0]  serial_data_port;
  logic        rx_pending;
  logic        quiet_armed;
  logic        ack;
  clr_seq_t    seq;
  logic [7:0]  tx_word;
  logic [7:0]  seen;

  // ****************************************
  // bus decode
  // ****************************************
  wire logic req       = avs_read_in | avs_write_in;
  wire logic take      = req & ack;
  wire logic hit_stat  = avs_address_in == STATUS_OFS;
  wire logic hit_data  = avs_address_in == DATA_OFS;
  wire logic hit_ctrl  = avs_address_in == CTRL_OFS;
  wire logic stat_acc  = take & hit_stat;
  wire logic data_wr   = take & avs_write_in & hit_data;
  wire logic data_rd   = take & avs_read_in & hit_data;
  wire logic armed     = seq == SEQ_ARMED;
  wire logic clr_tx    = armed & data_wr;
  wire logic clr_rx    = armed & data_rd;
  wire logic clr_par   = armed & (data_rd | data_wr);

  assign avs_waitrequest_out = req & ~ack;

  // ****************************************
  // transmit path
  // ****************************************
  wire logic tx_full   = ~status[TXE_BIT];
  wire logic tx_move   = tx_evt_in.load_ready & tx_full;
  wire logic tx_fin    = tx_evt_in.frame_done & tx_evt_in.frame_was_data;

  assign tx_load_out = tx_move;
  assign tx_word_out = tx_word;

  // ****************************************
  // receive path
  // ****************************************
  function automatic logic parity_bad(input logic [7:0] w, input logic p,
                                      input logic odd);
    parity_bad = (^{w, p}) != odd;
  endfunction

  wire logic rx_in     = rx_evt_in.word_done;
  wire logic rx_full   = status[RXR_BIT] & ~(clr_rx & seen[RXR_BIT]);
  wire logic rx_ovr    = rx_in & rx_full;
  wire logic rx_new    = rx_in & ~rx_full;
  wire logic rx_move   = rx_pending & ~rx_full;
  wire logic par_fail  = rx_new & ctrl[CTL_PAR_EN] &
                         parity_bad(rx_evt_in.word, rx_evt_in.parity_bit,
                                    ctrl[CTL_PAR_SEL]);
  wire logic quiet_set = rx_evt_in.idle_line & quiet_armed;

  // ****************************************
  // next status
  // ****************************************
  logic [7:0] next_status;
  always_comb begin
    next_status = status;
    // only flags seen at the status access are cleared
    if (clr_tx) begin
      next_status[TXE_BIT] = status[TXE_BIT] & ~seen[TXE_BIT];
      next_status[TXD_BIT] = status[TXD_BIT] & ~seen[TXD_BIT];
    end
    if (clr_rx) begin
      next_status[RXR_BIT] = status[RXR_BIT] & ~seen[RXR_BIT];
      next_status[IDL_BIT] = status[IDL_BIT] & ~seen[IDL_BIT];
      next_status[OVR_BIT] = status[OVR_BIT] & ~seen[OVR_BIT];
      next_status[NSE_BIT] = status[NSE_BIT] & ~seen[NSE_BIT];
      next_status[FRM_BIT] = status[FRM_BIT] & ~seen[FRM_BIT];
    end
    if (clr_par) begin
      next_status[PAR_BIT] = status[PAR_BIT] & ~seen[PAR_BIT];
    end
    // sets win over clears
    if (tx_move) begin
      next_status[TXE_BIT] = 1'b1;
    end
    if (tx_fin) begin
      next_status[TXD_BIT] = 1'b1;
    end
    if (rx_move) begin
      next_status[RXR_BIT] = 1'b1;
    end
    if (quiet_set) begin
      next_status[IDL_BIT] = 1'b1;
    end
    if (rx_ovr) begin
      next_status[OVR_BIT] = 1'b1;
    end
    if (rx_new & rx_evt_in.noise) begin
      next_status[NSE_BIT] = 1'b1;
    end
    if (rx_new & rx_evt_in.framing) begin
      next_status[FRM_BIT] = 1'b1;
    end
    if (par_fail) begin
      next_status[PAR_BIT] = 1'b1;
    end
  end

  // ****************************************
  // clear sequence tracker
  // ****************************************
  clr_seq_t next_seq;
  always_comb begin
    case (seq)
      SEQ_IDLE:  next_seq = stat_acc ? SEQ_ARMED : SEQ_IDLE;
      SEQ_ARMED: next_seq = stat_acc ? SEQ_ARMED :
                            (take & hit_data) ? SEQ_IDLE : SEQ_ARMED;
      default:   next_seq = SEQ_IDLE;
    endcase
  end

  // ****************************************
  // read mux
  // ****************************************
  wire logic [7:0] rd_byte = hit_stat ? status :
                             hit_data ? serial_data_port :
                             hit_ctrl ? ctrl : 8'h00;

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      status <= STATUS_RST;
      seq <= SEQ_IDLE;
      ack <= 1'b0;
    end else begin
      status <= next_status;
      seq <= next_seq;
      ack <= req & ~ack;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      ctrl <= CTRL_RST;
      tx_holding_reg <= 8'h00;
      tx_word <= 8'h00;
    end else begin
      if (take & avs_write_in & hit_ctrl) begin
        ctrl <= avs_writedata_in[7:0];
      end
      if (data_wr) begin
        tx_holding_reg <= avs_writedata_in[7:0];
      end
      if (tx_move) begin
        tx_word <= tx_holding_reg;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      rx_holding_reg <= 8'h00;
      serial_data_port <= 8'h00;
      rx_pending <= 1'b0;
    end else begin
      if (rx_new) begin
        rx_holding_reg <= rx_evt_in.word;
      end
      if (rx_move) begin
        serial_data_port <= rx_holding_reg;
      end
      rx_pending <= rx_new | (rx_pending & ~rx_move);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      quiet_armed <= 1'b1;
    end else if (quiet_set) begin
      quiet_armed <= 1'b0;
    end else if (rx_move) begin
      quiet_armed <= 1'b1;
    end
  end

  // status bits seen by the last status access
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      seen <= 8'h00;
    end else if (stat_acc) begin
      seen <= status;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (req & ~ack & avs_read_in) begin
      avs_readdata_out <= {24'h00_0000, rd_byte};
    end
  end

  // ****************************************
  // interrupt
  // ****************************************
  wire logic irq_txe   = next_status[TXE_BIT] &
                         ctrl[CTL_TX_EMPTY_IE];
  wire logic irq_txd   = next_status[TXD_BIT] &
                         ctrl[CTL_TX_DONE_IE];
  wire logic irq_rx    = (next_status[RXR_BIT] | next_status[OVR_BIT]) &
                         ctrl[CTL_RX_IE];
  wire logic irq_quiet = next_status[IDL_BIT] &
                         ctrl[CTL_QUIET_IE];
  wire logic irq_par   = next_status[PAR_BIT] &
                         ctrl[CTL_PAR_IE];

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= irq_txe | irq_txd | irq_rx | irq_quiet | irq_par;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_txe_sets: assert property (
    tx_move |=> status[TXE_BIT])
    else $error("tx empty not set");

  a_tx_word_load: assert property (
    tx_move |=> tx_word == $past(tx_holding_reg))
    else $error("tx word not loaded");

  a_irq_tx_empty: assert property (
    status[TXE_BIT] && ctrl[CTL_TX_EMPTY_IE] && $stable(status) &&
    $stable(ctrl) |-> irq_out)
    else $error("tx empty irq missing");

  a_txe_clear_pair: assert property (
    $fell(status[TXE_BIT]) |-> $past(clr_tx))
    else $error("tx empty clear bad");

  a_no_load_empty: assert property (
    status[TXE_BIT] |-> !tx_load_out)
    else $error("load while empty");

  a_done_only_data: assert property (
    $rose(status[TXD_BIT]) |-> $past(tx_fin))
    else $error("tx done bad set");

  a_txd_clears: assert property (
    clr_tx && seen[TXD_BIT] && !tx_fin |=> !status[TXD_BIT])
    else $error("tx done kept");

  a_rxr_sets: assert property (
    rx_move |=> status[RXR_BIT])
    else $error("rx ready not set");

  a_port_load: assert property (
    rx_move |=> serial_data_port == $past(rx_holding_reg))
    else $error("data port not loaded");

  a_rx_clear: assert property (
    clr_rx && seen[RXR_BIT] && !rx_move |=> !status[RXR_BIT])
    else $error("rx ready kept");

  a_idle_clear: assert property (
    clr_rx && seen[IDL_BIT] && !quiet_set |=> !status[IDL_BIT])
    else $error("idle kept");

  a_idle_sets: assert property (
    quiet_set |=> status[IDL_BIT])
    else $error("idle not set");

  a_idle_rearm: assert property (
    $rose(status[IDL_BIT]) |-> $past(quiet_armed))
    else $error("idle set while disarmed");

  a_ovr_sets: assert property (
    rx_ovr |=> status[OVR_BIT])
    else $error("overrun not set");

  a_ovr_holds: assert property (
    rx_ovr |=> $stable(rx_holding_reg))
    else $error("holding lost");

  a_noise_sets: assert property (
    rx_new && rx_evt_in.noise |=> status[NSE_BIT])
    else $error("noise not set");

  a_frame_sets: assert property (
    rx_new && rx_evt_in.framing |=> status[FRM_BIT])
    else $error("framing not set");

  a_ovr_no_frame: assert property (
    rx_ovr && !status[FRM_BIT] |=> !status[FRM_BIT])
    else $error("frame set");

  a_par_sets: assert property (
    par_fail |=> status[PAR_BIT])
    else $error("parity not set");

  a_irq_parity: assert property (
    status[PAR_BIT] && ctrl[CTL_PAR_IE] && $stable(status) && $stable(ctrl)
    |-> irq_out)
    else $error("parity irq missing");

  a_irq_off: assert property (
    $stable(status) && $stable(ctrl) && (status & ctrl & 8'hf0) == 8'h00 &&
    !(status[OVR_BIT] && ctrl[CTL_RX_IE]) &&
    !(status[PAR_BIT] && ctrl[CTL_PAR_IE]) |-> !irq_out)
    else $error("irq without enabled source");

  a_late_kept: assert property (
    clr_rx && !seen[RXR_BIT] && status[RXR_BIT] |=> status[RXR_BIT])
    else $error("late flag cleared");

  a_bus_wait: assert property (
    req && !ack |=> !avs_waitrequest_out || !req)
    else $error("wait too long");

  a_bus_first_wait: assert property (
    req && !ack |-> avs_waitrequest_out)
    else $error("no first wait");

  c_tx_clear: cover property (clr_tx);
  c_rx_ovr: cover property (rx_ovr);
  c_par_fail: cover property (par_fail);
  c_quiet_set: cover property (quiet_set);
  c_late_flag: cover property (clr_rx && !seen[RXR_BIT] && status[RXR_BIT]);

endmodule
`default_nettype wire

//--- tb/serial_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_engine_model
  import serial_flags_pkg::*;
(
  input  wire logic ref_clk_in,
  input  wire logic hold_in,
  input  wire logic tx_load_in,
  output tx_evt_t   tx_evt_out,
  output rx_evt_t   rx_evt_out
);
  // ****************************************
  // tx shifter: takes a word only when empty
  // ****************************************
  logic [3:0] busy = 4'h0;
  logic       pre  = 1'h0;
  logic       done = 1'h0;
  logic       dat  = 1'h0;

  assign tx_evt_out = '{(busy == 4'h0) && !hold_in, done, dat};
  initial rx_evt_out = '0;

  always @(posedge ref_clk_in) begin
    done <= (busy == 4'h1) || pre;
    dat  <= (busy == 4'h1);
    if (tx_load_in) begin
      busy <= 4'h8;
    end else if (busy != 4'h0) begin
      busy <= busy - 4'h1;
    end
  end

  // ****************************************
  // commanded events
  // ****************************************
  task automatic tx_preamble();
    pre <= 1'h1;
    @(posedge ref_clk_in);
    pre <= 1'h0;
  endtask

  // f = {parity bit, noise, framing, idle line}
  task automatic rx_send(input logic [7:0] w, input logic [3:0] f);
    rx_evt_out <= {!f[0], w, f};
    @(posedge ref_clk_in);
    rx_evt_out <= '0;
  endtask
endmodule
`default_nettype wire

//--- tb/test_async_serial_status_flags.sv
`timescale 1ns/1ps
`default_nettype none
module test_async_serial_status_flags;
  import serial_flags_pkg::*;
  logic        clk   = 1'h0;
  logic        srst  = 1'h1;
  logic [3:0]  addr  = 4'h0;
  logic        rd    = 1'h0;
  logic        wr    = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic        hold  = 1'h0;
  logic [31:0] rdata;
  logic        waitreq;
  logic        tx_load;
  logic [7:0]  tx_word;
  logic        irq;
  tx_evt_t     tx_evt;
  rx_evt_t     rx_evt;
  logic [7:0]  q;
  int          error_cnt   = 0;
  int          checks_done = 0;
  int          cyc         = 0;

  always #20 clk = ~clk;

  async_serial_status_flags async_serial_status_flags_inst (
    .ref_clk_in(clk), .srst_in(srst), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
    .tx_evt_in(tx_evt), .rx_evt_in(rx_evt), .tx_load_out(tx_load),
    .tx_word_out(tx_word), .irq_out(irq));

  serial_engine_model serial_engine_model_inst (
    .ref_clk_in(clk), .hold_in(hold), .tx_load_in(tx_load),
    .tx_evt_out(tx_evt), .rx_evt_out(rx_evt));

  // ****************************************
  // helpers
  // ****************************************
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      close_out();
    end
  end

  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d);
    addr  <= a;
    rd    <= !w;
    wr    <= w;
    wdata <= {24'h0, d};
    do @(posedge clk); while (waitreq !== 1'h0);
    q = rdata[7:0];
    rd <= 1'h0;
    wr <= 1'h0;
    @(posedge clk);
  endtask

  task automatic stat(input logic [7:0] e);
    bus(STATUS_OFS, 1'h0, 8'h0);
    cmp("status", e, q);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic irq_is(input logic e);
    tick(2);
    cmp("irq", {7'h0, e}, {7'h0, irq});
  endtask

  task automatic rx(input logic [7:0] w, input logic [3:0] f);
    serial_engine_model_inst.rx_send(w, f);
    tick(3);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    stat(8'hc0);
    bus(4'hc, 1'h0, 8'h0);
    cmp("unmapped", 8'h00, q);
    irq_is(1'h0);
  endtask

  task automatic t_tx();
    bus(CTRL_OFS, 1'h1, 8'h80);
    irq_is(1'h1);
    hold <= 1'h1;
    stat(8'hc0);
    bus(DATA_OFS, 1'h1, 8'h5a);
    tick(2);
    stat(8'h00);
    irq_is(1'h0);
    serial_engine_model_inst.tx_preamble();
    tick(2);
    stat(8'h00);
    hold <= 1'h0;
    tick(3);
    cmp("tx word", 8'h5a, tx_word);
    tick(12);
    stat(8'hc0);
    bus(CTRL_OFS, 1'h1, 8'h40);
    irq_is(1'h1);
  endtask

  task automatic t_rx();
    bus(CTRL_OFS, 1'h1, 8'h26);
    rx(8'ha5, 4'h8);
    stat(8'he0);
    irq_is(1'h1);
    rx(8'h3c, 4'h2);
    stat(8'he8);
    bus(DATA_OFS, 1'h0, 8'h0);
    cmp("data", 8'ha5, q);
    stat(8'hc0);
    irq_is(1'h0);
  endtask

  task automatic t_err();
    bus(CTRL_OFS, 1'h1, 8'h05);
    rx(8'ha5, 4'hc);
    stat(8'he5);
    irq_is(1'h1);
    bus(DATA_OFS, 1'h0, 8'h0);
    stat(8'hc0);
    bus(CTRL_OFS, 1'h1, 8'h00);
    rx(8'h11, 4'h6);
    stat(8'he6);
    irq_is(1'h0);
    bus(DATA_OFS, 1'h0, 8'h0);
  endtask

  task automatic t_idle();
    bus(CTRL_OFS, 1'h1, 8'h10);
    rx(8'h00, 4'h1);
    stat(8'hd0);
    irq_is(1'h1);
    bus(DATA_OFS, 1'h0, 8'h0);
    rx(8'h00, 4'h1);
    stat(8'hc0);
    rx(8'h42, 4'h0);
    rx(8'h00, 4'h1);
    stat(8'hf0);
  endtask

  task automatic t_late();
    bus(DATA_OFS, 1'h0, 8'h0);
    stat(8'hc0);
    rx(8'h77, 4'h0);
    bus(DATA_OFS, 1'h0, 8'h0);
    cmp("data", 8'h77, q);
    stat(8'he0);
    bus(DATA_OFS, 1'h0, 8'h0);
  endtask

  initial begin
    tick(20);
    srst <= 1'h0;
    @(posedge clk);
    t_reset();
    t_tx();
    t_rx();
    t_err();
    t_idle();
    t_late();
    close_out();
  end
endmodule
`default_nettype wire
